//--- rtl/bfs_params.svh
// bfs_params.svh: offsets, field positions and reset values of the fault status bank
// assumes inclusion by rtl/bfs_pkg.sv and rtl/bfs_fault_bank.sv
`ifndef BFS_PARAMS_SVH
`define BFS_PARAMS_SVH

// register indices; byte address is four times the index
`define BFS_IDX_SUMMARY      8'h52
`define BFS_IDX_CELL_LOW     8'h54
`define BFS_IDX_CELL_HIGH    8'h56
`define BFS_IDX_AUX          8'h58
`define BFS_IDX_CMP_LOW      8'h5a
`define BFS_IDX_CMP_HIGH     8'h5c
`define BFS_IDX_CONFIG       8'h60
`define BFS_IDX_IRQ_STATUS   8'h61
`define BFS_IDX_IRQ_MASK     8'h62

// summary bit positions
`define BFS_SUM_CELL_LOW     15
`define BFS_SUM_CELL_HIGH    14
`define BFS_SUM_AUX_LOW      13
`define BFS_SUM_AUX_HIGH     12
`define BFS_SUM_CMP_LOW      11
`define BFS_SUM_CMP_HIGH     10
`define BFS_SUM_LINK         9
`define BFS_SUM_SYSTEM       8
`define BFS_SUM_DIE          7
`define BFS_SUM_INPUT_PIN    6
`define BFS_SUM_LSB          6

// configuration field
`define BFS_CFG_SELF_CLEAR   0

// reset values
`define BFS_RST_FAULTS       16'h0000
`define BFS_RST_CONFIG       1'b0
`define BFS_RST_IRQ          10'h000

// axi responses
`define BFS_RESP_OKAY        2'b00
`define BFS_RESP_SLVERR      2'b10

`endif

//--- rtl/bfs_pkg.sv
// bfs_pkg: shared types of the fault status bank
// assumes bfs_params.svh is on the include path
`default_nettype none
`include "bfs_params.svh"

package bfs_pkg;
  typedef logic [15:0] bfs_word_t;
  typedef logic [9:0]  bfs_cat_t;
  typedef logic [7:0]  bfs_index_t;
endpackage : bfs_pkg
`default_nettype wire

//--- rtl/bfs_fault_bank.sv
// bfs_fault_bank: fault status registers of a 16-cell battery monitor, axi4-lite slave
// assumes stored results and thresholds come from logic on mclk_i; comparator flags are async
//
// Notes on behaviour
// - writing one to a summary bit clears all fault bits of that category, zero does nothing.
// - summary bits 15 to 6 read one while any fault bit of their category is set.
// - summary bits follow the live fault bits, which latch or self-clear per the mode bit.
// - summary bits 5 to 0 always read zero.
// - a cell low bit sets when its stored result is below the cell low threshold.
// - a cell high bit sets when its stored result is above the cell high threshold.
// - bit 0 of the cell and comparator registers is cell 1, rising with the cell number.
// - writing one to a per-channel fault bit clears it, writing zero leaves it.
// - in self-clear mode cell and aux bits drop once their condition is gone, else they latch.
// - the aux register holds aux low bits in 15:8 and aux high bits in 7:0, bit 0 is channel 0.
// - an aux low bit sets when its channel result is below that channel's low threshold.
// - an aux high bit sets when its channel result is above that channel's high threshold.
// - a comparator low bit sets when that cell's comparator reports undervoltage.
// - in self-clear mode comparator bits drop only when no analog-die fault exists, masked or not.
// - analog-die faults are system error bits 0 to 3 and every synchronised comparator low and high flag.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "bfs_params.svh"

module bfs_fault_bank
  import bfs_pkg::*;
(
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  // stored conversion results and thresholds, cell n+1 at slice n
  input  wire logic [255:0] cell_result_i,
  input  wire logic [15:0]  cell_low_threshold_i,
  input  wire logic [15:0]  cell_high_threshold_i,
  input  wire logic [127:0] aux_result_i,
  input  wire logic [127:0] aux_low_threshold_i,
  input  wire logic [127:0] aux_high_threshold_i,
  // analog comparator flags, asynchronous
  input  wire logic [15:0]  comparator_low_i,
  input  wire logic [15:0]  comparator_high_i,
  // other fault registers outside this bank
  input  wire logic [3:0]   system_error_i,
  input  wire logic [3:0]   ext_summary_i,
  output logic      [3:0]   ext_clear_o,
  // axi4-lite slave
  input  wire logic [9:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [9:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // interrupt
  output logic              irq_o
);

  bfs_word_t  cell_low_bits_q;
  bfs_word_t  cell_high_bits_q;
  logic [7:0] aux_low_bits_q;
  logic [7:0] aux_high_bits_q;
  bfs_word_t  comparator_low_bits_q;
  bfs_word_t  comparator_high_bits_q;
  logic       self_clear_mode_q;
  bfs_cat_t   irq_status_q;
  bfs_cat_t   irq_mask_q;
  bfs_cat_t   summary_prev_q;
  bfs_word_t  cmp_low_meta_q;
  bfs_word_t  cmp_low_sync_q;
  bfs_word_t  cmp_high_meta_q;
  bfs_word_t  cmp_high_sync_q;

  // detection conditions, one per cell and aux channel
  bfs_word_t  cell_low_cond;
  bfs_word_t  cell_high_cond;
  logic [7:0] aux_low_cond;
  logic [7:0] aux_high_cond;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_cell
      assign cell_low_cond[gi]  = cell_result_i[gi*16 +: 16] < cell_low_threshold_i;
      assign cell_high_cond[gi] = cell_result_i[gi*16 +: 16] > cell_high_threshold_i;
      if (gi < 8) begin : g_aux
        assign aux_low_cond[gi]  = aux_result_i[gi*16 +: 16] < aux_low_threshold_i[gi*16 +: 16];
        assign aux_high_cond[gi] = aux_result_i[gi*16 +: 16] > aux_high_threshold_i[gi*16 +: 16];
      end
    end
  endgenerate

  // comparator low synchroniser
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cmp_low_meta_q <= `BFS_RST_FAULTS;
      cmp_low_sync_q <= `BFS_RST_FAULTS;
    end else begin
      cmp_low_meta_q <= comparator_low_i;
      cmp_low_sync_q <= cmp_low_meta_q;
    end
  end

  // comparator high synchroniser
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cmp_high_meta_q <= `BFS_RST_FAULTS;
      cmp_high_sync_q <= `BFS_RST_FAULTS;
    end else begin
      cmp_high_meta_q <= comparator_high_i;
      cmp_high_sync_q <= cmp_high_meta_q;
    end
  end

  // write channel holding registers
  logic       aw_held_q;
  logic [9:0] awaddr_q;
  logic       w_held_q;
  bfs_word_t  wdata_q;
  logic [1:0] wstrb_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;

  // readies drop while a word is held, so nothing is overwritten
  assign s_axi_awready = ~aw_held_q;
  assign s_axi_wready  = ~w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  logic       wr_fire;
  bfs_index_t wr_idx;
  bfs_word_t  wr_ones;
  logic       wr_mapped;

  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_idx  = awaddr_q[9:2];
  // only the two low byte lanes reach the 16-bit registers
  assign wr_ones = wdata_q & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // unmapped indices answer slverr and change nothing
  always_comb begin
    case (wr_idx)
      `BFS_IDX_SUMMARY, `BFS_IDX_CELL_LOW, `BFS_IDX_CELL_HIGH, `BFS_IDX_AUX,
      `BFS_IDX_CMP_LOW, `BFS_IDX_CMP_HIGH, `BFS_IDX_CONFIG, `BFS_IDX_IRQ_STATUS,
      `BFS_IDX_IRQ_MASK: wr_mapped = 1'b1;
      default:           wr_mapped = 1'b0;
    endcase
  end

  // write address holding
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 10'h000;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      w_held_q <= 1'b0;
      wdata_q  <= `BFS_RST_FAULTS;
      wstrb_q  <= 2'h0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata[15:0];
      wstrb_q  <= s_axi_wstrb[1:0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // write response; a new write waits until bready drops bvalid
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `BFS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // clear vectors from register writes and summary writes
  logic      wr_sum;
  bfs_word_t clr_cell_low;
  bfs_word_t clr_cell_high;
  bfs_word_t clr_aux;
  bfs_word_t clr_cmp_low;
  bfs_word_t clr_cmp_high;

  assign wr_sum = wr_fire && (wr_idx == `BFS_IDX_SUMMARY);
  assign clr_cell_low  = (wr_fire && wr_idx == `BFS_IDX_CELL_LOW  ? wr_ones : 16'h0000)
                       | {16{wr_sum & wr_ones[`BFS_SUM_CELL_LOW]}};
  assign clr_cell_high = (wr_fire && wr_idx == `BFS_IDX_CELL_HIGH ? wr_ones : 16'h0000)
                       | {16{wr_sum & wr_ones[`BFS_SUM_CELL_HIGH]}};
  assign clr_aux       = (wr_fire && wr_idx == `BFS_IDX_AUX       ? wr_ones : 16'h0000)
                       | {{8{wr_sum & wr_ones[`BFS_SUM_AUX_LOW]}},
                          {8{wr_sum & wr_ones[`BFS_SUM_AUX_HIGH]}}};
  assign clr_cmp_low   = (wr_fire && wr_idx == `BFS_IDX_CMP_LOW   ? wr_ones : 16'h0000)
                       | {16{wr_sum & wr_ones[`BFS_SUM_CMP_LOW]}};
  assign clr_cmp_high  = (wr_fire && wr_idx == `BFS_IDX_CMP_HIGH  ? wr_ones : 16'h0000)
                       | {16{wr_sum & wr_ones[`BFS_SUM_CMP_HIGH]}};

  // any analog-die condition still present blocks comparator self-clear
  logic analog_die_fault;
  logic cmp_auto;
  assign analog_die_fault = (|system_error_i) | (|cmp_low_sync_q) | (|cmp_high_sync_q);
  assign cmp_auto         = self_clear_mode_q & ~analog_die_fault;

  // cell bits: set wins over clear
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cell_low_bits_q  <= `BFS_RST_FAULTS;
      cell_high_bits_q <= `BFS_RST_FAULTS;
    end else begin
      cell_low_bits_q  <= cell_low_cond
                        | (cell_low_bits_q & ~clr_cell_low & ~{16{self_clear_mode_q}});
      cell_high_bits_q <= cell_high_cond
                        | (cell_high_bits_q & ~clr_cell_high & ~{16{self_clear_mode_q}});
    end
  end

  // aux bits, same scheme as the cells
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      aux_low_bits_q  <= 8'h00;
      aux_high_bits_q <= 8'h00;
    end else begin
      aux_low_bits_q  <= aux_low_cond
                       | (aux_low_bits_q & ~clr_aux[15:8] & ~{8{self_clear_mode_q}});
      aux_high_bits_q <= aux_high_cond
                       | (aux_high_bits_q & ~clr_aux[7:0] & ~{8{self_clear_mode_q}});
    end
  end

  // comparator bits: hold while any analog-die fault remains
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      comparator_low_bits_q  <= `BFS_RST_FAULTS;
      comparator_high_bits_q <= `BFS_RST_FAULTS;
    end else begin
      comparator_low_bits_q  <= cmp_low_sync_q
                              | (comparator_low_bits_q & ~clr_cmp_low & ~{16{cmp_auto}});
      comparator_high_bits_q <= cmp_high_sync_q
                              | (comparator_high_bits_q & ~clr_cmp_high & ~{16{cmp_auto}});
    end
  end

  // summary of live state
  bfs_cat_t  summary;
  bfs_word_t summary_word;
  assign summary = {|cell_low_bits_q, |cell_high_bits_q, |aux_low_bits_q, |aux_high_bits_q,
                    |comparator_low_bits_q, |comparator_high_bits_q, ext_summary_i};
  assign summary_word = {summary, 6'h00};

  // clears for registers kept outside this bank
  assign ext_clear_o = wr_sum ? wr_ones[`BFS_SUM_LINK:`BFS_SUM_INPUT_PIN] : 4'h0;

  // self-clear mode, low byte lane only
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      self_clear_mode_q <= `BFS_RST_CONFIG;
    end else if (wr_fire && wr_idx == `BFS_IDX_CONFIG && wstrb_q[0]) begin
      self_clear_mode_q <= wdata_q[`BFS_CFG_SELF_CLEAR];
    end
  end

  // interrupt mask, per byte lane
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_mask_q <= `BFS_RST_IRQ;
    end else if (wr_fire && wr_idx == `BFS_IDX_IRQ_MASK) begin
      irq_mask_q <= (irq_mask_q & ~{{2{wstrb_q[1]}}, {8{wstrb_q[0]}}})
                  | (wdata_q[9:0] & {{2{wstrb_q[1]}}, {8{wstrb_q[0]}}});
    end
  end

  // read channel
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic       rd_fire;
  bfs_index_t rd_idx;
  bfs_word_t  rd_word;
  logic       rd_mapped;

  // one read in flight; arready returns once rvalid drops
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_fire       = s_axi_arvalid & ~rvalid_q;
  assign rd_idx        = s_axi_araddr[9:2];

  always_comb begin
    rd_mapped = 1'b1;
    case (rd_idx)
      `BFS_IDX_SUMMARY:    rd_word = summary_word;
      `BFS_IDX_CELL_LOW:   rd_word = cell_low_bits_q;
      `BFS_IDX_CELL_HIGH:  rd_word = cell_high_bits_q;
      `BFS_IDX_AUX:        rd_word = {aux_low_bits_q, aux_high_bits_q};
      `BFS_IDX_CMP_LOW:    rd_word = comparator_low_bits_q;
      `BFS_IDX_CMP_HIGH:   rd_word = comparator_high_bits_q;
      `BFS_IDX_CONFIG:     rd_word = {15'h0000, self_clear_mode_q};
      // status reads its value before the read clears it
      `BFS_IDX_IRQ_STATUS: rd_word = {6'h00, irq_status_q};
      `BFS_IDX_IRQ_MASK:   rd_word = {6'h00, irq_mask_q};
      default: begin
        rd_word   = 16'h0000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // read response flag and code
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `BFS_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_mapped ? `BFS_RESP_OKAY : `BFS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // read data, captured at the take so it stands until rready
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      rdata_q <= {16'h0000, rd_word};
    end
  end

  // interrupt status: rising summary bit sets, read clears, set wins
  bfs_cat_t irq_rise;
  logic     irq_rd_clr;
  assign irq_rise   = summary & ~summary_prev_q;
  assign irq_rd_clr = rd_fire && (rd_idx == `BFS_IDX_IRQ_STATUS);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      summary_prev_q <= `BFS_RST_IRQ;
      irq_status_q   <= `BFS_RST_IRQ;
    end else begin
      summary_prev_q <= summary;
      irq_status_q   <= irq_rise | (irq_rd_clr ? `BFS_RST_IRQ : irq_status_q);
    end
  end

  // interrupt line, registered so it cannot glitch
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule : bfs_fault_bank
`default_nettype wire

//--- testbench/bfs_fault_bank_chk.sv
// bfs_fault_bank_chk: port-level checks of the fault status bank
// assumes one clock, sync active-high reset, bound to every bfs_fault_bank
`timescale 1ns/100ps
`default_nettype none
module bfs_fault_bank_chk
  import bfs_pkg::*;
(
  // clock and reset
  input wire logic         mclk_i,
  input wire logic         reset_i,
  // fault sources
  input wire logic [255:0] cell_result_i,
  input wire logic [15:0]  cell_low_threshold_i,
  input wire logic [15:0]  cell_high_threshold_i,
  input wire logic [127:0] aux_result_i,
  input wire logic [127:0] aux_low_threshold_i,
  input wire logic [127:0] aux_high_threshold_i,
  input wire logic [3:0]   ext_summary_i,
  input wire logic [3:0]   ext_clear_o,
  // bus
  input wire logic [9:0]   s_axi_araddr,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_rvalid,
  input wire logic [31:0]  s_axi_rdata
);
  logic [9:0] ra_q;
  logic       tk;
  assign tk = s_axi_arvalid && !s_axi_rvalid;
  always_ff @(posedge mclk_i) begin
    if (tk) begin
      ra_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  AST_SUM_RSVD: assert property (
    s_axi_rvalid && ra_q == 10'h148 |-> s_axi_rdata[5:0] == 6'h00)
    else $error("summary low bits not zero");
  AST_CELL_LOW: assert property (
    tk && s_axi_araddr == 10'h150 && !$past(reset_i)
    && $past(cell_result_i[15:0] < cell_low_threshold_i) |=> s_axi_rdata[0])
    else $error("cell 1 low fault missing");
  AST_CELL_HIGH: assert property (
    tk && s_axi_araddr == 10'h158 && !$past(reset_i)
    && $past(cell_result_i[255:240] > cell_high_threshold_i) |=> s_axi_rdata[15])
    else $error("cell 16 high fault missing");
  AST_AUX_LOW: assert property (
    tk && s_axi_araddr == 10'h160 && !$past(reset_i)
    && $past(aux_result_i[15:0] < aux_low_threshold_i[15:0]) |=> s_axi_rdata[8])
    else $error("aux 0 low fault missing");
  AST_AUX_HIGH: assert property (
    tk && s_axi_araddr == 10'h160 && !$past(reset_i)
    && $past(aux_result_i[127:112] > aux_high_threshold_i[127:112]) |=> s_axi_rdata[7])
    else $error("aux 7 high fault missing");
  AST_SUM_CELL: assert property (
    tk && s_axi_araddr == 10'h148 && !$past(reset_i)
    && $past(cell_result_i[15:0] < cell_low_threshold_i) |=> s_axi_rdata[15])
    else $error("cell low summary missing");
  AST_SUM_EXT: assert property (
    tk && s_axi_araddr == 10'h148 && ext_summary_i[3] && $past(ext_summary_i[3])
    |=> s_axi_rdata[9])
    else $error("link summary missing");
  AST_EXT_CLR: assert property (
    ext_clear_o != 4'h0 |=> ext_clear_o == 4'h0 && s_axi_bvalid)
    else $error("category clear pulse wrong");
endmodule : bfs_fault_bank_chk
bind bfs_fault_bank bfs_fault_bank_chk i_chk (.*);
`default_nettype wire

//--- testbench/tb_bfs_fault_bank.sv
// tb_bfs_fault_bank: directed scenarios for the fault status bank
// assumes bfs_params.svh on the include path and the checker bound
`timescale 1ns/100ps
`default_nettype none
`include "bfs_params.svh"
module tb_bfs_fault_bank
  import bfs_pkg::*;
;
  localparam bfs_word_t MID = 16'h8000;
  logic mclk_i = 1'b0, reset_i = 1'b1;
  logic [255:0] cell_result_i = {16{MID}};
  logic [127:0] aux_result_i = {8{MID}};
  logic [15:0] cell_low_threshold_i = 16'h4000, cell_high_threshold_i = 16'hc000;
  logic [127:0] aux_low_threshold_i = {8{16'h4000}}, aux_high_threshold_i = {8{16'hc000}};
  logic [15:0] comparator_low_i = 16'h0, comparator_high_i = 16'h0;
  logic [3:0] system_error_i = 4'h0, ext_summary_i = 4'h0, ext_clear_o, s_axi_wstrb = 4'hf;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, wrsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq_o;
  logic [3:0] ext_seen = 4'h0;
  int error_cnt = 0, check_count = 0, cyc = 0;
  bfs_fault_bank i_dut (.*);
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (ext_clear_o != 4'h0) begin
      ext_seen <= ext_clear_o;
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic wr(input bfs_index_t a, input logic [15:0] d);
    @(posedge mclk_i);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input bfs_index_t a);
    @(posedge mclk_i);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rd_chk(input bfs_index_t a, input logic [31:0] exp);
    rd(a);
    cmp_word(rdat, exp);
    cmp_word({30'h0, rrsp}, {30'h0, `BFS_RESP_OKAY});
  endtask : rd_chk
  task automatic wait_irq(input logic e);
    for (int i = 0; i < 8 && irq_o !== e; i++) @(posedge mclk_i);
    cmp_bit(irq_o, e);
  endtask : wait_irq
  task automatic t_reset();
    rd_chk(`BFS_IDX_SUMMARY, 32'h0);
    rd_chk(`BFS_IDX_CONFIG, 32'h0);
    rd(8'h00);
    cmp_word({rdat[29:0], rrsp}, {30'h0, `BFS_RESP_SLVERR});
    wr(8'h00, 16'hffff);
    cmp_word({30'h0, wrsp}, {30'h0, `BFS_RESP_SLVERR});
  endtask : t_reset
  task automatic t_cell();
    @(posedge mclk_i);
    cell_result_i[31:0] <= {16'h4000, 16'h3fff};
    cell_result_i[255:224] <= {16'hc001, 16'hc000};
    rd_chk(`BFS_IDX_CELL_LOW, 32'h1);
    rd_chk(`BFS_IDX_CELL_HIGH, 32'h8000);
    rd_chk(`BFS_IDX_SUMMARY, 32'hc000);
    wr(`BFS_IDX_CELL_LOW, 16'h0001);
    cmp_word({30'h0, wrsp}, {30'h0, `BFS_RESP_OKAY});
    rd_chk(`BFS_IDX_CELL_LOW, 32'h1);
    @(posedge mclk_i);
    cell_result_i <= {16{MID}};
    wr(`BFS_IDX_CELL_LOW, 16'hfffe);
    wr(`BFS_IDX_SUMMARY, 16'h0000);
    rd_chk(`BFS_IDX_CELL_LOW, 32'h1);
    rd_chk(`BFS_IDX_CELL_HIGH, 32'h8000);
    wr(`BFS_IDX_CELL_LOW, 16'h0001);
    rd_chk(`BFS_IDX_CELL_LOW, 32'h0);
    wr(`BFS_IDX_SUMMARY, 16'h4000);
    rd_chk(`BFS_IDX_SUMMARY, 32'h0);
  endtask : t_cell
  task automatic t_aux();
    @(posedge mclk_i);
    aux_result_i[31:0] <= {16'hc000, 16'h3fff};
    aux_result_i[127:112] <= 16'hc001;
    rd_chk(`BFS_IDX_AUX, 32'h0180);
    @(posedge mclk_i);
    aux_result_i <= {8{MID}};
    wr(`BFS_IDX_AUX, 16'h0100);
    rd_chk(`BFS_IDX_SUMMARY, 32'h1000);
    wr(`BFS_IDX_SUMMARY, 16'h1000);
    rd_chk(`BFS_IDX_AUX, 32'h0);
  endtask : t_aux
  task automatic t_self_clear();
    wr(`BFS_IDX_CONFIG, 16'h0001);
    @(posedge mclk_i);
    cell_result_i[15:0] <= 16'h0000;
    rd_chk(`BFS_IDX_CELL_LOW, 32'h1);
    @(posedge mclk_i);
    cell_result_i[15:0] <= MID;
    rd_chk(`BFS_IDX_SUMMARY, 32'h0);
    @(posedge mclk_i);
    comparator_low_i[0] <= 1'b1;
    comparator_high_i[15] <= 1'b1;
    system_error_i <= 4'h8;
    repeat (4) @(posedge mclk_i);
    rd_chk(`BFS_IDX_CMP_LOW, 32'h1);
    rd_chk(`BFS_IDX_CMP_HIGH, 32'h8000);
    comparator_low_i[0] <= 1'b0;
    comparator_high_i[15] <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rd_chk(`BFS_IDX_SUMMARY, 32'h0c00);
    system_error_i <= 4'h0;
    repeat (4) @(posedge mclk_i);
    rd_chk(`BFS_IDX_SUMMARY, 32'h0);
  endtask : t_self_clear
  task automatic t_ext_irq();
    @(posedge mclk_i);
    ext_summary_i <= 4'hf;
    rd_chk(`BFS_IDX_SUMMARY, 32'h03c0);
    cmp_word({28'h0, ext_seen}, 32'h0);
    wr(`BFS_IDX_SUMMARY, 16'h03c0);
    cmp_word({28'h0, ext_seen}, 32'hf);
    ext_summary_i <= 4'h0;
    rd(`BFS_IDX_IRQ_STATUS);
    wr(`BFS_IDX_IRQ_MASK, 16'h0200);
    rd_chk(`BFS_IDX_IRQ_MASK, 32'h0200);
    cell_result_i[255:240] <= 16'hffff;
    repeat (6) @(posedge mclk_i);
    cmp_bit(irq_o, 1'b0);
    cell_result_i[15:0] <= 16'h0000;
    wait_irq(1'b1);
    rd_chk(`BFS_IDX_IRQ_STATUS, 32'h0300);
    wait_irq(1'b0);
  endtask : t_ext_irq
  task automatic t_mid_reset();
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd_chk(`BFS_IDX_CONFIG, 32'h0);
    rd_chk(`BFS_IDX_IRQ_MASK, 32'h0);
    rd_chk(`BFS_IDX_CELL_LOW, 32'h1);
    cmp_bit(irq_o, 1'b0);
  endtask : t_mid_reset
  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    t_cell();
    t_aux();
    t_self_clear();
    t_ext_irq();
    t_mid_reset();
    end_sim();
  end
endmodule : tb_bfs_fault_bank
`default_nettype wire
